// ===== src/txc_pkg.sv
// txc_pkg: shared constants and types of the legacy transmit command block
// assumes a 10 MHz system clock and a 32-bit APB register port
package txc_pkg;
   // command byte field positions
   localparam int CMD_LAST_FRAG_BIT = 0;
   localparam int CMD_CRC_APPEND_BIT = 1;
   localparam int CMD_CSUM_INSERT_BIT = 2;
   localparam int CMD_REPORT_BIT = 3;
   localparam int CMD_RSV_BIT = 4;
   localparam int CMD_EXTENSION_BIT = 5;
   localparam int CMD_VLAN_INSERT_BIT = 6;
   localparam int CMD_IRQ_DELAY_BIT = 7;
   // status byte field positions
   localparam int STA_DONE_BIT = 0;
   localparam int STA_EXCESS_COLL_BIT = 1;
   localparam int STA_LATE_COLL_BIT = 2;
   localparam int STA_W = 4;
   // vlan tag layout inside the special field
   localparam int TAG_PRI_MSB = 15;
   localparam int TAG_PRI_LSB = 13;
   localparam int TAG_CFI_BIT = 12;
   localparam int TAG_VID_MSB = 11;
   // frame layout
   localparam logic [15:0] MAC_ADDR_BYTES = 16'h000C;
   localparam logic [15:0] VLAN_HDR_BYTES = 16'h0004;
   // register map (byte addresses)
   localparam int APB_AW = 12;
   localparam logic [11:0] REG_CTRL_OFS = 12'h000;
   localparam logic [11:0] REG_IRQ_DELAY_OFS = 12'h004;
   localparam logic [11:0] REG_IRQ_MASK_OFS = 12'h008;
   localparam logic [11:0] REG_VLAN_TYPE_OFS = 12'h00C;
   localparam logic [11:0] REG_STATUS_OFS = 12'h010;
   localparam logic [15:0] VLAN_TYPE_RST = 16'h8100;
   localparam logic [15:0] IRQ_DELAY_RST = 16'h0000;
   localparam int CTRL_VLAN_MODE_BIT = 0;
   localparam int MASK_WRITEBACK_BIT = 0;
   localparam int STAT_RUN_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_CNT_LSB = 16;
   // delay timer granularity
   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_TIME_NS = 1000;
   localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) /
      CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      TXC_IDLE,
      TXC_RECV,
      TXC_DONE,
      TXC_EMIT
   } txc_state_e;
endpackage : txc_pkg

// ===== src/txc_csum_acc.sv
// txc_csum_acc: 16-bit ones-complement accumulator fed one byte at a time
// assumes the caller says which half of the 16-bit word each byte fills
`timescale 1ns/1ps
`default_nettype none
module txc_csum_acc
   import txc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic clear_i,
   input wire logic add_i,
   input wire logic high_i,
   input wire logic [7:0] byte_i,
   output logic [15:0] sum_o
);
   typedef struct packed {
      logic [15:0] sum;
   } txc_acc_s;

   txc_acc_s r;
   txc_acc_s n;

   // end-around carry; one fold suffices since two 16-bit values never
   // wrap twice
   function automatic logic [15:0] txc_fold(input logic [15:0] a,
                                            input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[15:0] + {15'h0000, s[16]};
   endfunction : txc_fold

   always_comb begin
      n = r;
      if (clear_i) begin
         n.sum = 16'h0000;
      end else if (add_i) begin
         n.sum = txc_fold(r.sum, high_i ? {byte_i, 8'h00} : {8'h00, byte_i});
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign sum_o = r.sum;
endmodule : txc_csum_acc
`default_nettype wire

// ===== src/txc_legacy_cmd.sv
// txc_legacy_cmd: interprets legacy transmit descriptor command bytes,
// assembles packets, inserts vlan tag and checksum, reports status and
// paces the transmit interrupt
// assumes descriptors and their payload bytes arrive from a fetch engine,
// and that the mac downstream appends the fcs when frame_fcs_o is high
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - load delay countdown on delayed report writeback
// - countdown zero raises interrupt when mask allows
// - every delay-enabled descriptor reloads the countdown
// - report without delay: immediate interrupt, timer cleared
// - vlan insert adds type register and tag
// - vlan insert needs global mode and last fragment
// - untagged frame: fcs follows crc append flag
// - report flag causes status writeback to descriptor
// - checksum from begin to end, inserted at position
// - checksum skipped if begin or position too far
// - crc and checksum flags only from last fragment
// - descriptors up to last fragment form one packet
// - byte-granular begin and position, 16-bit arithmetic
// - inserted vlan bytes excluded from checksum
// - done flag only in descriptors with report flag
// - status: done bit0, excess bit1, late bit2
// - tag built from priority, canonical bit, vlan id
module txc_legacy_cmd
   import txc_pkg::*;
#(
   parameter int PKT_DEPTH = 16384
)(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // apb register port
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [APB_AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // fetched descriptor
   input wire logic desc_valid_i,
   input wire logic [7:0] desc_command_byte_i,
   input wire logic [15:0] desc_len_i,
   input wire logic [7:0] desc_checksum_position_i,
   input wire logic [7:0] desc_checksum_begin_i,
   input wire logic [15:0] desc_special_i,
   output logic desc_ready_o,
   // payload bytes of the current descriptor
   input wire logic in_valid_i,
   input wire logic [7:0] in_data_i,
   output logic in_ready_o,
   // mac collision report for the write-back
   input wire logic mac_excess_collision_i,
   input wire logic mac_late_collision_i,
   // status write-back
   output logic wb_valid_o,
   output logic [STA_W-1:0] wb_status_byte_o,
   // outgoing frame
   output logic frame_valid_o,
   output logic [7:0] frame_data_o,
   output logic frame_last_o,
   output logic frame_fcs_o,
   input wire logic frame_ready_i,
   // transmit interrupt
   output logic tx_irq_o
);
   localparam int AW = $clog2(PKT_DEPTH);
   localparam int DIV_W = $clog2(TICK_CYCLES + 1);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);
   localparam logic [16:0] DEPTH_L = 17'(PKT_DEPTH);

   if (PKT_DEPTH < 64 || PKT_DEPTH > 65536 ||
       (PKT_DEPTH & (PKT_DEPTH - 1)) != 0) begin : g_depth_chk
      $error("PKT_DEPTH must be a power of two from 64 to 65536");
   end

   typedef struct packed {
      txc_state_e state;
      logic desc_rdy;
      logic in_rdy;
      logic [15:0] rem;
      logic [15:0] pkt_len;
      logic first;
      logic [7:0] cmd;
      logic [7:0] checksum_begin;
      logic [7:0] checksum_position;
      logic [15:0] special;
      logic vlan_on;
      logic csum_on;
      logic fcs_on;
      logic [15:0] emit_idx;
      logic [15:0] emit_total;
      logic out_valid;
      logic [7:0] out_data;
      logic out_last;
      logic wb_valid;
      logic [STA_W-1:0] wb_status;
      logic irq;
      logic cnt_run;
      logic [15:0] cnt;
      logic [DIV_W-1:0] div;
      logic ctrl_vlan;
      logic [15:0] irq_delay;
      logic irq_mask;
      logic [15:0] vlan_type;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } txc_state_s;

   txc_state_s r;
   txc_state_s n;

   logic [7:0] pkt_mem [PKT_DEPTH];
   logic mem_we;
   logic [AW-1:0] mem_waddr;
   logic csum_clr;
   logic csum_add;
   logic csum_hi;
   logic [15:0] csum_sum;
   logic [15:0] csum_fin;
   logic [15:0] rel;
   logic [15:0] src;
   logic [15:0] tag;
   logic tick;
   logic apb_setup;
   logic apb_write;
   logic last_frag;

   txc_csum_acc u_csum (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .clear_i(csum_clr),
      .add_i(csum_add),
      .high_i(csum_hi),
      .byte_i(in_data_i),
      .sum_o(csum_sum)
   );

   always_comb begin
      n = r;
      n.wb_valid = 1'b0;
      n.irq = 1'b0;
      mem_we = 1'b0;
      mem_waddr = r.pkt_len[AW-1:0];
      csum_clr = 1'b0;
      csum_add = 1'b0;
      csum_hi = 1'b0;
      csum_fin = ~csum_sum;
      rel = r.pkt_len - {8'h00, r.checksum_begin};
      src = r.emit_idx;
      last_frag = r.cmd[CMD_LAST_FRAG_BIT];
      tag = {r.special[TAG_PRI_MSB:TAG_PRI_LSB], r.special[TAG_CFI_BIT],
             r.special[TAG_VID_MSB:0]};

      // delay timer ticks once per TICK_TIME_NS
      tick = (r.div == DIV_LAST);
      n.div = tick ? '0 : r.div + 1'b1;
      if (r.cnt_run && tick) begin
         if (r.cnt <= 16'h0001) begin
            n.cnt = 16'h0000;
            n.cnt_run = 1'b0;
            n.irq = r.irq_mask;
         end else begin
            n.cnt = r.cnt - 16'h0001;
         end
      end

      unique case (r.state)
         TXC_IDLE: begin
            if (desc_valid_i && r.desc_rdy) begin
               n.cmd = desc_command_byte_i;
               n.rem = desc_len_i;
               n.checksum_position = desc_checksum_position_i;
               n.special = desc_special_i;
               if (r.first) begin
                  // begin offset belongs to the first descriptor
                  n.checksum_begin = desc_checksum_begin_i;
                  n.pkt_len = 16'h0000;
                  csum_clr = 1'b1;
               end
               n.state = (desc_len_i == 16'h0000) ? TXC_DONE : TXC_RECV;
            end
         end
         TXC_RECV: begin
            if (in_valid_i && r.in_rdy) begin
               // bytes past the buffer are dropped but still counted
               mem_we = ({1'b0, r.pkt_len} < DEPTH_L);
               if (r.pkt_len >= {8'h00, r.checksum_begin}) begin
                  csum_add = 1'b1;
                  csum_hi = ~rel[0];
               end
               n.pkt_len = r.pkt_len + 16'h0001;
               n.rem = r.rem - 16'h0001;
               if (r.rem == 16'h0001) begin
                  n.state = TXC_DONE;
               end
            end
         end
         TXC_DONE: begin
            if (r.cmd[CMD_REPORT_BIT]) begin
               n.wb_valid = 1'b1;
               n.wb_status = '0;
               n.wb_status[STA_DONE_BIT] = 1'b1;
               n.wb_status[STA_EXCESS_COLL_BIT] = mac_excess_collision_i;
               n.wb_status[STA_LATE_COLL_BIT] = mac_late_collision_i;
            end
            if (r.cmd[CMD_IRQ_DELAY_BIT]) begin
               n.cnt = r.irq_delay;
               n.cnt_run = 1'b1;
               n.irq = 1'b0;
            end else if (r.cmd[CMD_REPORT_BIT]) begin
               n.cnt = 16'h0000;
               n.cnt_run = 1'b0;
               n.irq = r.irq_mask;
            end
            n.first = last_frag;
            n.state = TXC_IDLE;
            if (last_frag) begin
               n.vlan_on = r.cmd[CMD_VLAN_INSERT_BIT] & r.ctrl_vlan;
               n.csum_on = r.cmd[CMD_CSUM_INSERT_BIT] &&
                  ({8'h00, r.checksum_begin} < r.pkt_len) &&
                  ({8'h00, r.checksum_position} + 16'h0001 < r.pkt_len);
               // tagged frames always get an fcs from the mac
               n.fcs_on = n.vlan_on | r.cmd[CMD_CRC_APPEND_BIT];
               n.emit_idx = 16'h0000;
               n.emit_total = r.pkt_len + (n.vlan_on ? VLAN_HDR_BYTES :
                                           16'h0000);
               if (r.pkt_len != 16'h0000) begin
                  n.state = TXC_EMIT;
               end
            end
         end
         TXC_EMIT: begin
            if (!r.out_valid || frame_ready_i) begin
               if (r.emit_idx < r.emit_total) begin
                  if (r.vlan_on && r.emit_idx >= MAC_ADDR_BYTES + VLAN_HDR_BYTES) begin
                     src = r.emit_idx - VLAN_HDR_BYTES;
                  end
                  if (r.vlan_on && r.emit_idx >= MAC_ADDR_BYTES &&
                      r.emit_idx < MAC_ADDR_BYTES + VLAN_HDR_BYTES) begin
                     unique case (r.emit_idx - MAC_ADDR_BYTES)
                        16'h0000: n.out_data = r.vlan_type[15:8];
                        16'h0001: n.out_data = r.vlan_type[7:0];
                        16'h0002: n.out_data = tag[15:8];
                        default: n.out_data = tag[7:0];
                     endcase
                  end else if (r.csum_on && src == {8'h00, r.checksum_position}) begin
                     n.out_data = csum_fin[15:8];
                  end else if (r.csum_on &&
                               src == {8'h00, r.checksum_position} + 16'h0001) begin
                     n.out_data = csum_fin[7:0];
                  end else begin
                     n.out_data = pkt_mem[src[AW-1:0]];
                  end
                  n.out_valid = 1'b1;
                  n.out_last = (r.emit_idx == r.emit_total - 16'h0001);
                  n.emit_idx = r.emit_idx + 16'h0001;
               end else begin
                  n.out_valid = 1'b0;
                  n.out_last = 1'b0;
                  n.state = TXC_IDLE;
               end
            end
         end
      endcase
      n.desc_rdy = (n.state == TXC_IDLE);
      n.in_rdy = (n.state == TXC_RECV) && (n.rem != 16'h0000);

      // apb slave: registered answer, one access cycle per transfer
      apb_setup = psel_i && !penable_i;
      apb_write = psel_i && penable_i && r.pready && pwrite_i && !r.pslverr;
      n.pready = apb_setup;
      if (apb_setup) begin
         n.prdata = 32'h0000_0000;
         n.pslverr = 1'b0;
         unique case (paddr_i)
            REG_CTRL_OFS: n.prdata[CTRL_VLAN_MODE_BIT] = r.ctrl_vlan;
            REG_IRQ_DELAY_OFS: n.prdata[15:0] = r.irq_delay;
            REG_IRQ_MASK_OFS: n.prdata[MASK_WRITEBACK_BIT] = r.irq_mask;
            REG_VLAN_TYPE_OFS: n.prdata[15:0] = r.vlan_type;
            REG_STATUS_OFS: begin
               n.prdata[STAT_RUN_BIT] = r.cnt_run;
               n.prdata[STAT_BUSY_BIT] = (r.state != TXC_IDLE);
               n.prdata[STAT_CNT_LSB+:16] = r.cnt;
            end
            default: n.pslverr = 1'b1;
         endcase
      end
      if (apb_write) begin
         unique case (paddr_i)
            REG_CTRL_OFS: n.ctrl_vlan = pwdata_i[CTRL_VLAN_MODE_BIT];
            REG_IRQ_DELAY_OFS: n.irq_delay = pwdata_i[15:0];
            REG_IRQ_MASK_OFS: n.irq_mask = pwdata_i[MASK_WRITEBACK_BIT];
            REG_VLAN_TYPE_OFS: n.vlan_type = pwdata_i[15:0];
            default: n.prdata = r.prdata;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         r <= '0;
         r.state <= TXC_IDLE;
         r.first <= 1'b1;
         r.vlan_type <= VLAN_TYPE_RST;
         r.irq_delay <= IRQ_DELAY_RST;
      end else begin
         r <= n;
      end
   end

   // packet store has no reset: only bytes written this packet are read, except for tagged packets shorter than 12 bytes
   always_ff @(posedge sys_clk_i) begin
      if (mem_we) begin
         pkt_mem[mem_waddr] <= in_data_i;
      end
   end

   assign prdata_o = r.prdata;
   assign pready_o = r.pready;
   assign pslverr_o = r.pslverr;
   assign desc_ready_o = r.desc_rdy;
   assign in_ready_o = r.in_rdy;
   assign wb_valid_o = r.wb_valid;
   assign wb_status_byte_o = r.wb_status;
   assign frame_valid_o = r.out_valid;
   assign frame_data_o = r.out_data;
   assign frame_last_o = r.out_last;
   assign frame_fcs_o = r.fcs_on;
   assign tx_irq_o = r.irq;
endmodule : txc_legacy_cmd
`default_nettype wire

// ===== testbench/txc_legacy_cmd_sva.sv
// txc_legacy_cmd_sva: port-level assertions for the legacy command block
// assumes one clock domain and the register map of txc_pkg
`timescale 1ns/1ps
`default_nettype none
module txc_legacy_cmd_sva
   import txc_pkg::*;
#(
   parameter int PKT_DEPTH = 16384
)(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [APB_AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic desc_valid_i,
   input wire logic [7:0] desc_command_byte_i,
   input wire logic desc_ready_o,
   input wire logic wb_valid_o,
   input wire logic [STA_W-1:0] wb_status_byte_o,
   input wire logic frame_valid_o,
   input wire logic [7:0] frame_data_o,
   input wire logic frame_last_o,
   input wire logic frame_fcs_o,
   input wire logic frame_ready_i,
   input wire logic tx_irq_o
);
   logic [7:0] cmd_r;
   logic mask_r;
   // shadow of the last taken command and of the mask register
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cmd_r <= 8'h00;
         mask_r <= 1'b0;
      end else begin
         if (desc_valid_i && desc_ready_o) begin
            cmd_r <= desc_command_byte_i;
         end
         if (psel_i && penable_i && pready_o && pwrite_i &&
               paddr_i == REG_IRQ_MASK_OFS) begin
            mask_r <= pwdata_i[MASK_WRITEBACK_BIT];
         end
      end
   end

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   sequence s_take;
      desc_valid_i && desc_ready_o;
   endsequence
   sequence s_last_out;
      frame_valid_o && frame_ready_i && frame_last_o;
   endsequence

   a_apb_answer: assert property (psel_i && !penable_i |=> pready_o)
      else $error("apb access not answered in one cycle");
   a_ready_once: assert property (pready_o |=> !pready_o)
      else $error("pready longer than one cycle");
   a_err_unmapped: assert property (pready_o |->
      pslverr_o == (paddr_i > REG_STATUS_OFS || paddr_i[1:0] != 2'h0))
      else $error("pslverr does not match address map");
   a_take_drop: assert property (s_take |=> !desc_ready_o)
      else $error("descriptor ready stays high after take");
   a_wb_report: assert property (wb_valid_o |-> cmd_r[CMD_REPORT_BIT])
      else $error("write-back without report request");
   a_wb_layout: assert property (wb_valid_o |->
      wb_status_byte_o[STA_DONE_BIT] && !wb_status_byte_o[3])
      else $error("write-back status layout wrong");
   a_wb_pulse: assert property (wb_valid_o |=> !wb_valid_o)
      else $error("write-back pulse too long");
   a_irq_now: assert property (wb_valid_o && cmd_r[CMD_REPORT_BIT] &&
      !cmd_r[CMD_IRQ_DELAY_BIT] |-> tx_irq_o == mask_r)
      else $error("immediate interrupt wrong");
   a_irq_held: assert property (wb_valid_o && cmd_r[CMD_IRQ_DELAY_BIT] &&
      cmd_r[CMD_REPORT_BIT] |-> !tx_irq_o)
      else $error("delayed interrupt fired at write-back");
   a_irq_mask: assert property (tx_irq_o |-> mask_r)
      else $error("interrupt while masked");
   a_frame_hold: assert property (frame_valid_o && !frame_ready_i |=>
      frame_valid_o && $stable(frame_data_o))
      else $error("frame byte changed while stalled");
   a_fcs_steady: assert property (frame_valid_o && $past(frame_valid_o) |->
      $stable(frame_fcs_o))
      else $error("fcs request changed inside frame");
   a_frame_end: assert property (s_last_out |=>
      !frame_valid_o ##[0:1] desc_ready_o)
      else $error("frame end not followed by idle");
endmodule : txc_legacy_cmd_sva
bind txc_legacy_cmd txc_legacy_cmd_sva #(.PKT_DEPTH(PKT_DEPTH)) u_sva (
   .sys_clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
   .pwdata_i, .pready_o, .pslverr_o, .desc_valid_i, .desc_command_byte_i,
   .desc_ready_o, .wb_valid_o, .wb_status_byte_o, .frame_valid_o,
   .frame_data_o, .frame_last_o, .frame_fcs_o, .frame_ready_i, .tx_irq_o);
`default_nettype wire

// ===== testbench/txc_host_model.sv
// txc_host_model: host side offering one descriptor and its payload bytes
// assumes the caller holds the descriptor inputs until busy_o falls
`timescale 1ns/1ps
`default_nettype none
module txc_host_model (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic go_i,
   input wire logic slow_i,
   input wire logic [7:0] cmd_i,
   input wire logic [15:0] len_i,
   input wire logic [7:0] seed_i,
   input wire logic desc_ready_i,
   input wire logic in_ready_i,
   output logic [7:0] desc_cmd_o,
   output logic desc_valid_o,
   output logic in_valid_o,
   output logic [7:0] in_data_o,
   output logic busy_o
);
   logic [15:0] cnt;
   logic ph;
   // extension and reserved bits always zero; offloads force crc append
   assign desc_cmd_o = (cmd_i & 8'hCF) |
      {6'h00, cmd_i[2] | cmd_i[6], 1'b0};
   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         desc_valid_o <= 1'b0;
         in_valid_o <= 1'b0;
         in_data_o <= 8'h00;
         busy_o <= 1'b0;
         cnt <= 16'h0000;
         ph <= 1'b0;
      end else begin
         ph <= ~ph;
         if (go_i) begin
            desc_valid_o <= 1'b1;
            busy_o <= 1'b1;
            cnt <= 16'h0000;
         end
         if (desc_valid_o && desc_ready_i) begin
            desc_valid_o <= 1'b0;
         end
         // released data line shows the inverse, not a stale byte
         if (in_valid_o && in_ready_i) begin
            cnt <= cnt + 16'h0001;
            in_valid_o <= 1'b0;
            in_data_o <= ~in_data_o;
         end else if (busy_o && !desc_valid_o && cnt < len_i &&
               !(slow_i && ph)) begin
            in_valid_o <= 1'b1;
            in_data_o <= seed_i + cnt[7:0];
         end
         if (busy_o && !desc_valid_o && cnt == len_i && !in_valid_o) begin
            busy_o <= 1'b0;
         end
      end
   end
endmodule : txc_host_model
`default_nettype wire

// ===== testbench/test_txc_legacy_cmd.sv
// test_txc_legacy_cmd: apb and descriptor driven checks of the command block
// assumes txc_host_model as descriptor source and a stalling frame sink
`timescale 1ns/1ps
`default_nettype none
module test_txc_legacy_cmd;
   import txc_pkg::*;
   logic sys_clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o;
   logic pslverr_o, desc_valid_i, desc_ready_o, in_valid_i, in_ready_o;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, r, s;
   logic [7:0] desc_command_byte_i, desc_checksum_position_i;
   logic [7:0] desc_checksum_begin_i, in_data_i, frame_data_o, cmd, seed;
   logic [15:0] desc_len_i, desc_special_i, ck;
   logic mac_excess_collision_i, mac_late_collision_i, wb_valid_o, e;
   logic [STA_W-1:0] wb_status_byte_o, wb_seen;
   logic frame_valid_o, frame_last_o, frame_fcs_o, frame_ready_i, tx_irq_o;
   logic go, slow, busy, stall, fcs_seen, irq_wb;
   logic [7:0] got[$], exp[$], p[14];
   int error_cnt, n_checks, nfr, wb_cnt, irq_cnt, k, n0, i0;

   txc_legacy_cmd #(.PKT_DEPTH(256)) txc_legacy_cmd_inst (.sys_clk_i,
      .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .desc_valid_i, .desc_command_byte_i,
      .desc_len_i, .desc_checksum_position_i, .desc_checksum_begin_i,
      .desc_special_i, .desc_ready_o, .in_valid_i, .in_data_i, .in_ready_o,
      .mac_excess_collision_i, .mac_late_collision_i, .wb_valid_o,
      .wb_status_byte_o, .frame_valid_o, .frame_data_o, .frame_last_o,
      .frame_fcs_o, .frame_ready_i, .tx_irq_o);
   txc_host_model txc_host_model_inst (.sys_clk_i, .reset_i, .go_i(go),
      .slow_i(slow), .cmd_i(cmd), .len_i(desc_len_i), .seed_i(seed),
      .desc_ready_i(desc_ready_o), .in_ready_i(in_ready_o),
      .desc_cmd_o(desc_command_byte_i), .desc_valid_o(desc_valid_i),
      .in_valid_o(in_valid_i), .in_data_o(in_data_i), .busy_o(busy));

   initial begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      frame_ready_i <= stall ? ~frame_ready_i : 1'b1;
      if (frame_valid_o && frame_ready_i) begin
         got.push_back(frame_data_o);
         fcs_seen = frame_fcs_o;
         if (frame_last_o) nfr++;
      end
      if (wb_valid_o) begin
         wb_cnt++;
         wb_seen = wb_status_byte_o;
         irq_wb = tx_irq_o;
      end
      if (tx_irq_o) irq_cnt++;
   end

   task chk(input string nm, input logic [31:0] x, input logic [31:0] y);
      n_checks++;
      if (y !== x) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, x, y);
         error_cnt++;
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      // no fixed wait: only the watchdog ends a missing answer
      do @(posedge sys_clk_i); while (pready_o !== 1'b1);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask : apb
   task desc(input logic [7:0] c, input logic [15:0] l, input logic [7:0] b,
         input logic [7:0] q, input logic [15:0] v, input logic [7:0] sd);
      cmd <= c;
      desc_len_i <= l;
      desc_checksum_begin_i <= b;
      desc_checksum_position_i <= q;
      desc_special_i <= v;
      seed <= sd;
      go <= 1'b1;
      @(posedge sys_clk_i);
      go <= 1'b0;
      @(posedge sys_clk_i);
      while (busy) @(posedge sys_clk_i);
   endtask : desc
   task frame_chk(input logic f);
      while (nfr == n0) @(posedge sys_clk_i);
      chk("frame length", exp.size(), got.size());
      foreach (exp[i]) chk("frame byte", exp[i], got[i]);
      chk("fcs request", f, fcs_seen);
      got.delete();
      exp.delete();
      n0 = nfr;
   endtask : frame_chk
   task results;
      if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results

   initial begin
      repeat (5000) @(posedge sys_clk_i);
      error_cnt++;
      results();
   end
   initial begin
      {reset_i, psel_i, penable_i, pwrite_i, go, slow, stall} = 7'h41;
      {paddr_i, pwdata_i, cmd, seed, desc_len_i} = '0;
      {desc_checksum_begin_i, desc_checksum_position_i} = 16'h0000;
      {desc_special_i, mac_excess_collision_i, mac_late_collision_i} = '0;
      frame_ready_i = 1'b1;
      repeat (3) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      @(posedge sys_clk_i);
      apb(1'b0, REG_VLAN_TYPE_OFS, 32'h0);
      chk("vlan type reset", {16'h0000, VLAN_TYPE_RST}, r);
      apb(1'b0, 12'h040, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, e});
      apb(1'b1, REG_IRQ_MASK_OFS, 32'h1);
      apb(1'b1, REG_VLAN_TYPE_OFS, 32'h88A8);
      apb(1'b1, REG_CTRL_OFS, 32'h1);
      apb(1'b1, REG_IRQ_DELAY_OFS, 32'h2);
      n0 = nfr;
      mac_excess_collision_i <= 1'b1;
      desc(8'h09, 16'd3, 8'h00, 8'h00, 16'h0000, 8'h40);
      for (k = 0; k < 3; k++) exp.push_back(8'h40 + k[7:0]);
      frame_chk(1'b0);
      chk("status first", 32'h3, {28'h0, wb_seen});
      chk("irq at write-back", 32'h1, {31'h0, irq_wb});
      {mac_excess_collision_i, mac_late_collision_i, slow, stall} <= 4'h7;
      desc(8'h00, 16'd6, 8'd11, 8'h00, 16'h0000, 8'h10);
      i0 = irq_cnt;
      desc(8'hCD, 16'd8, 8'h00, 8'd12, 16'hA123, 8'h16);
      for (k = 0; k < 14; k++) p[k] = 8'h10 + k[7:0];
      s = 32'h0;
      // odd begin: byte 11 fills the high half of the first word
      for (k = 11; k < 14; k++) s += (k % 2) ? {p[k], 8'h00} : p[k];
      s = s[15:0] + s[31:16];
      ck = ~s[15:0];
      p[12] = ck[15:8];
      p[13] = ck[7:0];
      for (k = 0; k < 12; k++) exp.push_back(p[k]);
      exp.push_back(8'h88);
      exp.push_back(8'hA8);
      exp.push_back(8'hA1);
      exp.push_back(8'h23);
      exp.push_back(p[12]);
      exp.push_back(p[13]);
      frame_chk(1'b1);
      chk("status second", 32'h5, {28'h0, wb_seen});
      chk("no irq at write-back", 32'h0, {31'h0, irq_wb});
      repeat (40) @(posedge sys_clk_i);
      chk("delayed irq count", i0 + 1, irq_cnt);
      {slow, stall} <= 2'h0;
      apb(1'b1, REG_CTRL_OFS, 32'h0);
      i0 = wb_cnt;
      desc(8'h45, 16'd4, 8'h00, 8'd3, 16'hFFFF, 8'h60);
      for (k = 0; k < 4; k++) exp.push_back(8'h60 + k[7:0]);
      frame_chk(1'b1);
      chk("no write-back", i0, wb_cnt);
      results();
   end
endmodule : test_txc_legacy_cmd
`default_nettype wire
